// [rtl/smsa_pkg.sv]
// constants and types shared by the serial mux converter interface
package smsa_pkg;

    // supported multiplexer variants
    localparam int unsigned CHAN_1 = 1;
    localparam int unsigned CHAN_2 = 2;
    localparam int unsigned CHAN_4 = 4;
    localparam int unsigned CHAN_8 = 8;

    // result and field widths
    localparam int unsigned RES_W     = 8;
    localparam int unsigned SEL_W     = 2;
    localparam int unsigned CH_W      = 4;
    localparam int unsigned CNT_W     = 3;
    localparam int unsigned BIT_IDX_W = 3;
    localparam int unsigned TAIL_W    = 4;

    // synchroniser depth and pin positions in the synchronised vector
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned PIN_W       = 5;
    localparam int unsigned PIN_CS_N    = 4;
    localparam int unsigned PIN_SCLK    = 3;
    localparam int unsigned PIN_DIN     = 2;
    localparam int unsigned PIN_SE_N    = 1;
    localparam int unsigned PIN_COMP    = 0;

    // address word field slots, in arrival order after the start bit
    localparam logic [CNT_W-1:0] FLD_SGL = 3'h0;
    localparam logic [CNT_W-1:0] FLD_ODD = 3'h1;

    // conversion sequencing values
    localparam logic [RES_W-1:0]     CODE_ZERO  = 8'h00;
    localparam logic [RES_W-1:0]     CODE_MSB   = 8'h80;
    localparam logic [BIT_IDX_W-1:0] BIT_MSB    = 3'h7;
    localparam logic [BIT_IDX_W-1:0] BIT_LSB    = 3'h0;
    localparam logic [TAIL_W-1:0]    TAIL_FIRST = 4'h1;
    localparam logic [TAIL_W-1:0]    TAIL_END   = 4'h8;

    // channel codes on the analog selection outputs
    localparam logic [CH_W-1:0] CH_IN_POS = 4'h0;
    localparam logic [CH_W-1:0] CH_IN_NEG = 4'h1;
    localparam logic [CH_W-1:0] CH_COM    = 4'h8;
    localparam logic [CH_W-1:0] CH_GND    = 4'h9;
    localparam logic [CH_W-1:0] CH_NONE   = 4'hF;

    typedef enum logic [2:0] {
        ST_WAIT_START,
        ST_ADDR,
        ST_SETTLE,
        ST_CONVERT,
        ST_TAIL,
        ST_DONE
    } smsa_state_t;

    // number of address bits following the start bit
    function automatic int unsigned smsa_mux_bits(input int unsigned ch);
        return (ch == CHAN_8) ? 4 : (ch == CHAN_4) ? 3 : (ch == CHAN_2) ? 2 : 0;
    endfunction

endpackage

// [rtl/smsa_mux_if.sv]
// address fields and decoded channel selection between controller and decoder
`timescale 1ns/1ps
interface smsa_mux_if
    import smsa_pkg::*;
();
    logic             single_not_diff;
    logic             odd_sign;
    logic [SEL_W-1:0] select;
    logic [CH_W-1:0]  pos_ch;
    logic [CH_W-1:0]  neg_ch;

    modport ctrl (output single_not_diff, output odd_sign, output select,
                  input pos_ch, input neg_ch);
    modport dec  (input single_not_diff, input odd_sign, input select,
                  output pos_ch, output neg_ch);
endinterface

// [rtl/smsa_sync.sv]
// two-stage synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
module smsa_sync
    import smsa_pkg::*;
#(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_i, // sampling clock
    input  wire logic [W-1:0] d_i,   // asynchronous inputs
    output logic      [W-1:0] q_o    // synchronised outputs
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i)
    begin
        meta_r <= d_i;
        sync_r <= meta_r;
    end

    assign q_o = sync_r;
endmodule // smsa_sync

// [rtl/smsa_mux_dec.sv]
// channel assignment decoder for the input multiplexer variants
`timescale 1ns/1ps
module smsa_mux_dec
    import smsa_pkg::*;
#(
    parameter int unsigned CHANNELS = CHAN_8
) (
    smsa_mux_if.dec mux // address fields in, channel codes out
);
    always_comb
    begin
        // pairs and single channels both index as twice select plus odd/sign
        mux.pos_ch = CH_W'({mux.select, mux.odd_sign});
        if (mux.single_not_diff)
        begin
            mux.neg_ch = (CHANNELS == CHAN_8) ? CH_COM : CH_GND;
        end
        else
        begin
            mux.neg_ch = CH_W'({mux.select, ~mux.odd_sign});
        end
        if (CHANNELS == CHAN_1)
        begin
            mux.pos_ch = CH_IN_POS;
            mux.neg_ch = CH_IN_NEG;
        end
    end
endmodule // smsa_mux_dec

// [rtl/smsa_conv_ctrl.sv]
// serial interface and conversion sequencer of the multiplexed converter
`timescale 1ns/1ps
// Function
// - During addressing, serial input is sampled on each rising converter clock edge.
// - Leading zeros are ignored; the first sampled one is the start bit.
// - A 2-to-4-bit multiplexer word follows the start bit, by variant.
// - Eight channels, differential: select picks pair, odd/sign swaps polarity.
// - Eight channels, single: channel is twice select plus odd/sign, against common.
// - Four channels: same single mapping against ground; differential picks 0/1 or 2/3.
// - Two channels: odd/sign picks channel, or swaps the pair polarity.
// - Every conversion takes a fresh input configuration.
// - Half a clock period of idle settling follows the last address bit.
// - Settling raises conversion active and disables serial input until deselect.
// - Serial output leaves high impedance at settling and drives a leading zero.
// - Each decision appears on serial output at a falling edge, MSB first.
// - Conversion lasts 8 periods; active drops half a period afterwards.
// - Result is kept and, without shift enable, replayed LSB first.
// - After the LSB-first stream the output is held low until deselect.
// - Eight channels: shift enable high holds LSB; low shifts LSB first.
// - Single-channel variant gives only the MSB-first stream.
// - Single-channel variant has one fixed differential input, no address word.
// - Chip select high keeps every internal register cleared except the pin synchroniser and the converter clock edge register.
// - Input is only sampled while the output is still high impedance.
// - Positive input below negative input yields an all-zero code.
// - The result is an 8-bit code of 256 values.
module smsa_conv_ctrl
    import smsa_pkg::*;
#(
    parameter int unsigned CHANNELS = CHAN_8
) (
    input  wire logic             core_clk_i,             // system clock, 200 MHz
    input  wire logic             sys_rst_i,              // synchronous reset, active high
    input  wire logic             chip_select_n_i,        // chip select pin, active low
    input  wire logic             conv_clk_i,             // converter clock pin
    input  wire logic             serial_in_i,            // serial data in pin
    input  wire logic             lsb_shift_enable_n_i,   // lsb shift enable pin, active low
    input  wire logic             comp_gt_i,              // comparator: input above trial
    output logic                  data_out_o,             // serial data out level
    output logic                  data_out_oe_o,          // serial data out drive enable
    output logic                  conversion_active_o,    // conversion in progress
    output logic      [RES_W-1:0] trial_code_o,           // trial level to the ladder
    output logic      [CH_W-1:0]  pos_ch_o,               // channel on the positive input
    output logic      [CH_W-1:0]  neg_ch_o                // channel on the negative input
);
    localparam int unsigned MUX_BITS = smsa_mux_bits(CHANNELS);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'((MUX_BITS == 0) ? 0 : MUX_BITS - 1);

    logic [PIN_W-1:0]     pins_raw;
    logic [PIN_W-1:0]     pins_s;
    logic                 cs_n_s;
    logic                 sclk_s;
    logic                 din_s;
    logic                 se_n_s;
    logic                 comp_s;
    logic                 sclk_d_r;
    logic                 sclk_rise;
    logic                 sclk_fall;
    logic                 clear;
    logic                 tail_adv;
    smsa_state_t          state_r;
    logic                 sgl_r;
    logic                 odd_r;
    logic [SEL_W-1:0]     sel_r;
    logic [CNT_W-1:0]     addr_cnt_r;
    logic [RES_W-1:0]     trial_r;
    logic [RES_W-1:0]     trial_nxt;
    logic [RES_W-1:0]     result_r;
    logic [BIT_IDX_W-1:0] bit_idx_r;
    logic [TAIL_W-1:0]    tail_idx_r;
    logic                 dout_r;
    logic                 dout_oe_r;
    logic                 active_r;
    logic [CH_W-1:0]      pos_r;
    logic [CH_W-1:0]      neg_r;

    smsa_mux_if mux ();

    // every pin, the comparator included, is asynchronous to core_clk_i
    assign pins_raw = {chip_select_n_i, conv_clk_i, serial_in_i,
                       lsb_shift_enable_n_i, comp_gt_i};

    smsa_sync #(
        .W (PIN_W)
    ) u_sync (
        .clk_i (core_clk_i),
        .d_i   (pins_raw),
        .q_o   (pins_s)
    );

    assign cs_n_s = pins_s[PIN_CS_N];
    assign sclk_s = pins_s[PIN_SCLK];
    assign din_s  = pins_s[PIN_DIN];
    assign se_n_s = pins_s[PIN_SE_N];
    assign comp_s = pins_s[PIN_COMP];

    // converter clock must run well below core_clk_i/4 for clean edge detection
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            sclk_d_r <= 1'b0;
        else
            sclk_d_r <= sclk_s;
    end

    assign sclk_rise = sclk_s & ~sclk_d_r;
    assign sclk_fall = ~sclk_s & sclk_d_r;
    // deselect acts as the device reset
    assign clear     = sys_rst_i | cs_n_s;
    // the eight-channel variant parks on the lsb while shift enable is high
    assign tail_adv  = !((CHANNELS == CHAN_8) && se_n_s);

    always_ff @(posedge core_clk_i)
    begin
        if (clear)
        begin
            state_r <= ST_WAIT_START;
        end
        else
        begin
            case (state_r)
                ST_WAIT_START:
                    if (sclk_rise && din_s)
                        state_r <= (MUX_BITS == 0) ? ST_SETTLE : ST_ADDR;
                ST_ADDR:
                    if (sclk_rise && addr_cnt_r == CNT_LAST)
                        state_r <= ST_SETTLE;
                ST_SETTLE:
                    if (sclk_fall)
                        state_r <= ST_CONVERT;
                ST_CONVERT:
                    if (sclk_fall && bit_idx_r == BIT_LSB)
                        state_r <= ST_TAIL;
                ST_TAIL:
                    if (sclk_fall && (CHANNELS == CHAN_1
                                      || (tail_adv && tail_idx_r == TAIL_END)))
                        state_r <= ST_DONE;
                ST_DONE:
                    state_r <= ST_DONE;
                default:
                    state_r <= ST_WAIT_START;
            endcase
        end
    end

    // address fields are rebuilt from scratch for each conversion
    always_ff @(posedge core_clk_i)
    begin
        if (clear)
        begin
            sgl_r      <= 1'b0;
            odd_r      <= 1'b0;
            sel_r      <= '0;
            addr_cnt_r <= '0;
        end
        else if (state_r == ST_ADDR && sclk_rise)
        begin
            if (addr_cnt_r == FLD_SGL)
                sgl_r <= din_s;
            else if (addr_cnt_r == FLD_ODD)
                odd_r <= din_s;
            else
                sel_r <= {sel_r[SEL_W-2:0], din_s};
            addr_cnt_r <= addr_cnt_r + 1'b1;
        end
    end

    assign mux.single_not_diff = sgl_r;
    assign mux.odd_sign        = odd_r;
    assign mux.select          = sel_r;

    smsa_mux_dec #(
        .CHANNELS (CHANNELS)
    ) u_mux_dec (
        .mux (mux)
    );

    // selection is presented from settling onward so the channel can settle
    always_ff @(posedge core_clk_i)
    begin
        if (clear || state_r == ST_WAIT_START || state_r == ST_ADDR)
        begin
            pos_r <= CH_NONE;
            neg_r <= CH_NONE;
        end
        else
        begin
            pos_r <= mux.pos_ch;
            neg_r <= mux.neg_ch;
        end
    end

    // keep the decided bit, set the next trial bit below it
    always_comb
    begin
        trial_nxt            = trial_r;
        trial_nxt[bit_idx_r] = comp_s;
        if (bit_idx_r != BIT_LSB)
            trial_nxt[bit_idx_r - 1'b1] = 1'b1;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (clear)
        begin
            trial_r   <= CODE_ZERO;
            result_r  <= CODE_ZERO;
            bit_idx_r <= BIT_MSB;
        end
        else if (state_r == ST_SETTLE && sclk_fall)
        begin
            trial_r   <= CODE_MSB;
            result_r  <= CODE_ZERO;
            bit_idx_r <= BIT_MSB;
        end
        else if (state_r == ST_CONVERT && sclk_fall)
        begin
            // a reversed input pair keeps the comparator low: all-zero code
            result_r[bit_idx_r] <= comp_s;
            trial_r             <= trial_nxt;
            bit_idx_r           <= bit_idx_r - 1'b1;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (clear)
            tail_idx_r <= TAIL_FIRST;
        else if (state_r == ST_TAIL && sclk_fall && tail_adv && tail_idx_r != TAIL_END)
            tail_idx_r <= tail_idx_r + 1'b1;
    end

    // output stays released through addressing, so the pins may share a wire
    always_ff @(posedge core_clk_i)
    begin
        if (clear)
        begin
            dout_r    <= 1'b0;
            dout_oe_r <= 1'b0;
        end
        else if (sclk_fall)
        begin
            case (state_r)
                ST_SETTLE:
                begin
                    dout_oe_r <= 1'b1;
                    dout_r    <= 1'b0;
                end
                ST_CONVERT:
                    dout_r <= comp_s;
                ST_TAIL:
                    // shift enable high parks the line even at the stream end, like the state
                    if (CHANNELS == CHAN_1 || (tail_adv && tail_idx_r == TAIL_END))
                        dout_r <= 1'b0;
                    else if (tail_adv)
                        dout_r <= result_r[tail_idx_r[BIT_IDX_W-1:0]];
                ST_DONE:
                    dout_r <= 1'b0;
                default:
                    dout_r <= dout_r;
            endcase
        end
    end

    // active rises with settling, falls at the rising edge after the last decision
    always_ff @(posedge core_clk_i)
    begin
        if (clear)
            active_r <= 1'b0;
        else if (state_r == ST_SETTLE && sclk_fall)
            active_r <= 1'b1;
        else if (state_r == ST_TAIL && sclk_rise)
            active_r <= 1'b0;
    end

    assign data_out_o          = dout_r;
    assign data_out_oe_o       = dout_oe_r;
    assign conversion_active_o = active_r;
    assign trial_code_o        = trial_r;
    assign pos_ch_o            = pos_r;
    assign neg_ch_o            = neg_r;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence seq_settle_fall;
        state_r == ST_SETTLE && sclk_fall && !cs_n_s;
    endsequence

    sequence seq_last_decision;
        state_r == ST_CONVERT && sclk_fall && bit_idx_r == BIT_LSB && !cs_n_s;
    endsequence

    sequence seq_drive_zero;
        conversion_active_o && data_out_oe_o && !data_out_o;
    endsequence

    AST_CS_CLEARS: assert property (cs_n_s |=> state_r == ST_WAIT_START
        && !data_out_oe_o && !conversion_active_o && result_r == CODE_ZERO)
        else $error("deselect did not clear the converter");

    AST_ZERO_IGNORED: assert property (
        state_r == ST_WAIT_START && sclk_rise && !din_s && !cs_n_s
        |=> state_r == ST_WAIT_START)
        else $error("leading zero taken as start bit");

    AST_START_TAKEN: assert property (
        state_r == ST_WAIT_START && sclk_rise && din_s && !cs_n_s
        |=> state_r == ((MUX_BITS == 0) ? ST_SETTLE : ST_ADDR))
        else $error("start bit not taken");

    AST_RELEASED_ADDR: assert property (
        (state_r == ST_WAIT_START || state_r == ST_ADDR) |-> !data_out_oe_o)
        else $error("output driven during addressing");

    AST_SETTLE_ZERO: assert property (seq_settle_fall |=> seq_drive_zero)
        else $error("settling did not raise active with a leading zero");

    AST_DECISION_OUT: assert property (
        state_r == ST_CONVERT && sclk_fall && !cs_n_s
        |=> data_out_o == $past(comp_s) && result_r[$past(bit_idx_r)] == $past(comp_s))
        else $error("decision not shown on serial output");

    AST_EIGHT_DECISIONS: assert property (
        seq_last_decision |=> state_r == ST_TAIL && conversion_active_o)
        else $error("conversion did not end after the lsb decision");

    AST_ACTIVE_DROP: assert property (
        state_r == ST_TAIL && sclk_rise && !cs_n_s |=> !conversion_active_o)
        else $error("active not dropped after conversion");

    AST_SE_HOLD: assert property (
        CHANNELS == CHAN_8 && state_r == ST_TAIL && se_n_s && !cs_n_s
        |=> $stable(data_out_o))
        else $error("output moved while shift enable was high");

    AST_DONE_LOW: assert property (
        state_r == ST_DONE |-> !data_out_o && data_out_oe_o)
        else $error("output not held low after the result");

endmodule // smsa_conv_ctrl

// [test/smsa_analog_model.sv]
// behavioural analog front end: channel levels, selection and comparator
`timescale 1ns/1ps
module smsa_analog_model
    import smsa_pkg::*;
(
    input  wire logic [8:0][7:0]  volts_i,   // channels 0..7, then common
    input  wire logic [CH_W-1:0]  pos_ch_i,  // positive selection
    input  wire logic [CH_W-1:0]  neg_ch_i,  // negative selection
    input  wire logic [RES_W-1:0] trial_i,   // ladder trial level
    output logic                  comp_gt_o  // selected input above trial
);
    // ground and unselected inputs read as zero
    function automatic int level(input logic [CH_W-1:0] ch);
        return (ch <= CH_COM) ? int'(volts_i[ch]) : 0;
    endfunction

    // a reversed pair never trips the comparator, so its code stays zero
    always_comb comp_gt_o = (level(pos_ch_i) - level(neg_ch_i)) > int'(trial_i);
endmodule // smsa_analog_model

// [test/tb.sv]
// self-checking bench for the serial mux converter interface
`timescale 1ns/1ps
module tb;
    import smsa_pkg::*;
    logic             core_clk_i;
    logic             sys_rst_i;
    logic             cs_n;
    logic             cclk;
    logic             din;
    logic             se_n;
    logic             comp;
    logic             dout;
    logic             oe;
    logic             act;
    logic [RES_W-1:0] trial;
    logic [CH_W-1:0]  pos;
    logic [CH_W-1:0]  neg;
    logic [8:0][7:0]  volts;
    logic             s_dout;
    logic             s_oe;
    logic             s_act;
    logic             e_act;
    int               n_errors;
    int               compares;

    smsa_conv_ctrl #(.CHANNELS(CHAN_8)) u_smsa_conv_ctrl (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .chip_select_n_i(cs_n),
        .conv_clk_i(cclk), .serial_in_i(din), .lsb_shift_enable_n_i(se_n),
        .comp_gt_i(comp), .data_out_o(dout), .data_out_oe_o(oe),
        .conversion_active_o(act), .trial_code_o(trial), .pos_ch_o(pos), .neg_ch_o(neg));

    smsa_analog_model u_smsa_analog_model (
        .volts_i(volts), .pos_ch_i(pos), .neg_ch_i(neg), .trial_i(trial), .comp_gt_o(comp));

    initial
    begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    task automatic print_verdict();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // expected {pos, neg}: pair polarity follows odd/sign, single ends use common
    function automatic logic [7:0] exp_ch(input logic [3:0] w);
        if (w[3])
            return {1'b0, w[1:0], w[2], CH_COM};
        return {1'b0, w[1:0], w[2], 1'b0, w[1:0], ~w[2]};
    endfunction

    function automatic logic [7:0] exp_code(input int v);
        logic [7:0] r;
        r = 8'h00;
        for (int b = 7; b >= 0; b--)
            if (v > int'(r | (8'h01 << b)))
                r = r | (8'h01 << b);
        return r;
    endfunction

    // one converter clock period: fall, low phase, rise, high phase
    task automatic cyc(input logic d, input logic se);
        cclk = 1'b0;
        din = d;
        se_n = se;
        repeat (7) @(negedge core_clk_i);
        s_dout = dout;
        s_oe = oe;
        s_act = act;
        @(negedge core_clk_i);
        cclk = 1'b1;
        repeat (8) @(negedge core_clk_i);
        e_act = act;
    endtask

    task automatic frame(input logic [3:0] word, input int lead, input int abort_at);
        logic [4:0] w;
        logic [7:0] ch;
        logic [7:0] code;
        int         p;
        int         holds;
        w = {1'b1, word};
        ch = exp_ch(word);
        code = exp_code(int'(volts[ch[7:4]]) - int'(volts[ch[3:0]]));
        holds = $urandom_range(3, 0);
        cs_n = 1'b0;
        repeat (4) @(negedge core_clk_i);
        for (int i = 0; i < lead; i++)
            cyc(1'b0, 1'b1);
        for (int i = 4; i >= 0; i--)
        begin
            cyc(w[i], 1'b1);
            check(8'(s_oe), 8'h00);
        end
        cyc(1'($urandom), 1'b1);
        check(8'({s_dout, s_oe, s_act}), 8'h03);
        check({pos, neg}, ch);
        for (int b = 7; b >= 0; b--)
        begin
            cyc(1'($urandom), 1'b1);
            check(8'(s_dout), 8'(code[b]));
            if (b == abort_at)
                break;
        end
        if (abort_at < 0)
        begin
            check(8'({s_act, e_act}), 8'h02);
            check(trial, code);
            p = 0;
            for (int j = 0; j < holds + 9; j++)
            begin
                cyc(1'($urandom), 1'(j < holds));
                if (j >= holds)
                    p++;
                check(8'(s_dout), (p < 8) ? 8'(code[p]) : 8'h00);
            end
        end
        cs_n = 1'b1;
        repeat (6) @(negedge core_clk_i);
        check(8'({dout, oe, act}), 8'h00);
        check(trial, 8'h00);
        check({pos, neg}, 8'hFF);
    endtask

    initial
    begin
        #200us;
        n_errors++;
        print_verdict();
    end

    initial
    begin
        sys_rst_i = 1'b1;
        cs_n = 1'b1;
        cclk = 1'b0;
        din = 1'b0;
        se_n = 1'b1;
        volts = '0;
        n_errors = 0;
        compares = 0;
        void'($urandom(11));
        repeat (8) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        // every mux word once, random levels and leading zeros
        for (int i = 0; i < 16; i++)
        begin
            for (int k = 0; k < 9; k++)
                volts[k] = 8'($urandom);
            frame(4'(i), $urandom_range(2, 0), -1);
        end
        // reversed input: common above the channel must give an all-zero code
        volts[0] = 8'h10;
        volts[8] = 8'hF0;
        frame(4'h8, 0, -1);
        // full-scale input, then deselect in mid-conversion and restart
        volts[1] = 8'hFF;
        volts[8] = 8'h00;
        frame(4'hC, 1, -1);
        frame(4'hC, 0, 4);
        frame(4'h4, 2, -1);
        print_verdict();
    end
endmodule // tb
